// ---- rtl/tcd_pkg.sv ----
// Shared constants and types for the Type-C configuration-channel detect block
package tcd_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL0 = 8'h00;
    localparam logic [7:0] OFS_CTRL1 = 8'h04;
    localparam logic [7:0] OFS_STAT0 = 8'h08;
    localparam logic [7:0] OFS_STAT1 = 8'h0c;
    localparam logic [7:0] OFS_EVT = 8'h10;
    localparam logic [7:0] OFS_MASK = 8'h14;
    localparam logic [7:0] OFS_STRAP = 8'h18;
    localparam int NPORT = 2;
    // Control field positions (per-port control register)
    localparam int CF_ROLE = 0;   // [1:0]
    localparam int CF_ADV = 2;    // [3:2]
    localparam int CF_FRS_EN = 4;
    localparam int CF_FRS_REQ = 5;
    localparam int CF_TRIM_SEL = 6;
    localparam int CF_DB_OFF = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // Status field positions
    localparam int SF_STATE = 0;  // [3:0]
    localparam int SF_ORIENT = 4;
    localparam int SF_VBUS = 5;
    localparam int SF_VCONN = 6;
    localparam int SF_SINKING = 7;
    localparam int SF_ADV_SEEN = 8; // [9:8]
    localparam int SF_PULLUP = 10;
    localparam int SF_RD_TRIM = 11;
    localparam int SF_DEAD_BATTERY_PULLDOWN = 12;
    localparam int SF_FRS_PD = 13;
    // Event bits per port: attach, detach, swap detected, swap sent
    localparam int EV_ATT = 0;
    localparam int EV_DET = 1;
    localparam int EV_FRS_RX = 2;
    localparam int EV_FRS_TX = 3;
    localparam int EV_W = 4;
    // Timing: dual-role toggle half period
    localparam int DRP_HALF_US = 35;
    localparam int CLK_MHZ = 125;
    localparam int DRP_HALF_CYC = DRP_HALF_US * CLK_MHZ;
    localparam int STRAP_W = 8;

    typedef enum logic [1:0] {ROLE_SRC, ROLE_SNK, ROLE_DRP, ROLE_OFF} tcd_role_t;
    typedef enum logic [1:0] {ADV_DEF500, ADV_DEF900, ADV_1A5, ADV_3A0} tcd_adv_t;
    // Comparator outcome per line as seen from the analog front end
    typedef enum logic [1:0] {TERM_OPEN, TERM_RD, TERM_RA} tcd_term_t;
    typedef enum logic [3:0] {
        CS_UNATT, CS_UFP, CS_CABLE, CS_CABLE_UFP, CS_DEBUG, CS_AUDIO, CS_SNK_WAIT, CS_SNK_ATT
    } tcd_cstate_t;
endpackage

// ---- rtl/tcd_port.sv ----
// One port of configuration-channel attach, orientation, role and swap logic
`timescale 1ns/100ps
module tcd_port
    import tcd_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [7:0] ctrl,
    input wire logic dead_batt,
    input wire logic vbus_present,
    input wire logic [1:0] cc1_rd_cmp,
    input wire logic [1:0] cc1_ra_cmp,
    input wire logic [1:0] cc2_rd_cmp,
    input wire logic [1:0] cc2_ra_cmp,
    input wire logic [1:0] frs_low,
    output logic [13:0] status,
    output logic [EV_W-1:0] evt
);
    // cc*_rd_cmp: bit0 below sink-detect threshold, bit1 below cable-detect threshold of the chosen level
    tcd_role_t role;
    tcd_adv_t adv;
    tcd_cstate_t st_r, st_nxt;
    tcd_term_t t1, t2;
    logic orient_r, drp_src_r, sinking_r, sourcing_r, frs_pd_r;
    logic [13:0] toggle_cnt_r;
    logic src_mode, att_now, att_prev_r;
    logic [1:0] adv_seen_r;
    logic detach_ev, frs_rx, frs_tx;

    assign role = tcd_role_t'(ctrl[CF_ROLE+1:CF_ROLE]);
    assign adv = tcd_adv_t'(ctrl[CF_ADV+1:CF_ADV]);

    // Line classification: Ra pulls lower than Rd
    function automatic tcd_term_t classify(input logic [1:0] c);
        if (c[1]) return TERM_RA;
        if (c[0]) return TERM_RD;
        return TERM_OPEN;
    endfunction
    assign t1 = classify(cc1_rd_cmp);
    assign t2 = classify(cc2_rd_cmp);

    // Dual-role toggling between pull-up and pull-down while in CS_UNATT or CS_SNK_WAIT (not in CS_CABLE)
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            toggle_cnt_r <= '0;
            drp_src_r <= 1'b0;
        end else if (role == ROLE_DRP && (st_r == CS_UNATT || st_r == CS_SNK_WAIT)) begin
            if (toggle_cnt_r == 14'(DRP_HALF_CYC - 1)) begin
                toggle_cnt_r <= '0;
                drp_src_r <= !drp_src_r;
            end else begin
                toggle_cnt_r <= toggle_cnt_r + 14'h0001;
            end
        end else begin
            toggle_cnt_r <= '0;
        end
    end

    // A completed swap overrides the configured role until swap is disabled or the role is off; under ROLE_SRC a sink swap ends once CF_FRS_REQ clears
    assign src_mode = role != ROLE_OFF &&
                      (sourcing_r || (!sinking_r && (role == ROLE_SRC || (role == ROLE_DRP && drp_src_r))));

    always_comb begin
        st_nxt = st_r;
        detach_ev = 1'b0;
        if (role == ROLE_OFF) begin
            st_nxt = CS_UNATT;
        end else if (src_mode) begin
            case (st_r)
                CS_UNATT, CS_CABLE: begin
                    // Open/open goes to or stays in CS_UNATT; Ra+open is a powered cable only
                    if (t1 == TERM_RD && t2 == TERM_RD) st_nxt = CS_DEBUG;
                    else if (t1 == TERM_RA && t2 == TERM_RA) st_nxt = CS_AUDIO;
                    else if ((t1 == TERM_RD && t2 == TERM_RA) || (t1 == TERM_RA && t2 == TERM_RD))
                        st_nxt = CS_CABLE_UFP;
                    else if (t1 == TERM_RD || t2 == TERM_RD) st_nxt = CS_UFP;
                    else if (t1 == TERM_RA || t2 == TERM_RA) st_nxt = CS_CABLE;
                    else st_nxt = CS_UNATT;
                end
                CS_UFP, CS_CABLE_UFP: begin
                    // Only the sink line is watched; the Ra line is ignored
                    if (!(orient_r ? cc2_rd_cmp[0] : cc1_rd_cmp[0])) begin
                        st_nxt = CS_UNATT;
                        detach_ev = 1'b1;
                    end
                end
                CS_DEBUG, CS_AUDIO: begin
                    if (!cc1_rd_cmp[0] || !cc2_rd_cmp[0]) begin
                        st_nxt = CS_UNATT;
                        detach_ev = 1'b1;
                    end
                end
                default: st_nxt = CS_UNATT;
            endcase
        end else begin
            case (st_r)
                CS_SNK_ATT: begin
                    if (!vbus_present) begin
                        st_nxt = CS_SNK_WAIT;
                        detach_ev = 1'b1;
                    end
                end
                default: st_nxt = vbus_present ? CS_SNK_ATT : CS_SNK_WAIT;
            endcase
        end
    end

    assign att_now = (st_nxt == CS_UFP || st_nxt == CS_CABLE_UFP || st_nxt == CS_DEBUG ||
                      st_nxt == CS_AUDIO || st_nxt == CS_SNK_ATT);
    assign frs_rx = ctrl[CF_FRS_EN] && st_r == CS_SNK_ATT && (orient_r ? frs_low[1] : frs_low[0]);
    assign frs_tx = ctrl[CF_FRS_EN] && src_mode && st_r != CS_UNATT && ctrl[CF_FRS_REQ] && !frs_pd_r;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r <= CS_UNATT;
            orient_r <= 1'b0;
            att_prev_r <= 1'b0;
            evt <= '0;
        end else begin
            st_r <= st_nxt;
            att_prev_r <= att_now;
            // Orientation names the line carrying the sink (or partner pull-up)
            if (st_r == CS_UNATT || st_r == CS_CABLE || st_r == CS_SNK_WAIT)
                orient_r <= src_mode ? (t2 == TERM_RD && t1 != TERM_RD) : (cc2_rd_cmp[0] && !cc1_rd_cmp[0]);
            evt[EV_ATT] <= att_now && !att_prev_r;
            evt[EV_DET] <= detach_ev;
            evt[EV_FRS_RX] <= frs_rx;
            evt[EV_FRS_TX] <= frs_tx;
        end
    end

    // Swap: sink turns into source on detect, source into sink after signalling
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sinking_r <= 1'b0;
            sourcing_r <= 1'b0;
            frs_pd_r <= 1'b0;
        end else begin
            if (frs_rx) begin
                sourcing_r <= 1'b1;
                sinking_r <= 1'b0;
            end else if (frs_pd_r) begin
                sinking_r <= 1'b1;
                sourcing_r <= 1'b0;
            end else if (!ctrl[CF_FRS_EN] || role == ROLE_OFF) begin
                sinking_r <= 1'b0;
                sourcing_r <= 1'b0;
            end else if (role == ROLE_SRC) begin
                sinking_r <= 1'b0;
            end
            if (frs_tx) frs_pd_r <= 1'b1;
            else if (!ctrl[CF_FRS_REQ]) frs_pd_r <= 1'b0;
        end
    end

    // Advertised level from the partner's pull-up strength
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) adv_seen_r <= '0;
        else if (st_r == CS_SNK_ATT) adv_seen_r <= orient_r ? cc2_ra_cmp : cc1_ra_cmp;
        else adv_seen_r <= '0;
    end

    always_comb begin
        status = '0;
        status[SF_STATE+3:SF_STATE] = st_r;
        status[SF_ORIENT] = orient_r;
        status[SF_VBUS] = (st_r == CS_UFP || st_r == CS_CABLE_UFP);
        status[SF_VCONN] = (st_r == CS_CABLE_UFP);
        status[SF_SINKING] = !src_mode;
        status[SF_ADV_SEEN+1:SF_ADV_SEEN] = adv_seen_r;
        status[SF_PULLUP] = src_mode && role != ROLE_OFF;
        // Dead-battery pull-down stays until firmware selects trim or removes it
        status[SF_DEAD_BATTERY_PULLDOWN] = !src_mode && dead_batt && !ctrl[CF_TRIM_SEL] && !ctrl[CF_DB_OFF];
        status[SF_RD_TRIM] = !src_mode && role != ROLE_OFF && !status[SF_DEAD_BATTERY_PULLDOWN];
        status[SF_FRS_PD] = frs_pd_r;
    end
endmodule

// ---- rtl/tcd_sync2.sv ----
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module tcd_sync2 #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// ---- rtl/tcd_top.sv ----
// APB-reached two-port Type-C configuration-channel detect block
`timescale 1ns/100ps
module tcd_top
    import tcd_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NPORT-1:0] vbus_present,
    input wire logic [NPORT-1:0] dead_batt,
    input wire logic [2*NPORT-1:0] cc_line_one_cmp,
    input wire logic [2*NPORT-1:0] cc_line_two_cmp,
    input wire logic [2*NPORT-1:0] cc_line_one_lvl,
    input wire logic [2*NPORT-1:0] cc_line_two_lvl,
    input wire logic [2*NPORT-1:0] swap_low,
    input wire logic [STRAP_W-1:0] bus_power_strap,
    input wire logic strap_valid,
    output logic [14*NPORT-1:0] port_status,
    output logic irq
);
    import tcd_pkg::*;
    // All comparator pins are async to mclk
    localparam int PW = 2 + 12 * NPORT;
    logic [PW-1:0] pin_raw, pin_s;
    logic [7:0] ctrl_r [NPORT];
    logic [13:0] stat [NPORT];
    logic [EV_W-1:0] pev [NPORT];
    logic [2*EV_W-1:0] evt_r, mask_r, ev_in;
    logic [STRAP_W-1:0] strap_r;
    logic strap_done_r, strap_vs;
    logic acc, wr, rd_evt;
    logic [31:0] rd_nxt;
    logic [STRAP_W-1:0] strap_s;

    assign pin_raw = {strap_valid, 1'b0, vbus_present, dead_batt, cc_line_one_cmp, cc_line_two_cmp,
                      cc_line_one_lvl, cc_line_two_lvl, swap_low};
    tcd_sync2 #(.W(PW)) u_sync (.mclk(mclk), .nrst(nrst), .d(pin_raw), .q(pin_s));
    tcd_sync2 #(.W(STRAP_W)) u_ssync (.mclk(mclk), .nrst(nrst), .d(bus_power_strap), .q(strap_s));
    assign strap_vs = pin_s[PW-1];

    genvar g;
    generate
        for (g = 0; g < NPORT; g++) begin : g_port
            localparam int B = 2 * g;
            tcd_port u_port (
                .mclk(mclk),
                .nrst(nrst),
                .ctrl(ctrl_r[g]),
                .dead_batt(pin_s[10*NPORT+g]),
                .vbus_present(pin_s[11*NPORT+g]),
                .cc1_rd_cmp(pin_s[8*NPORT+B+1:8*NPORT+B]),
                .cc2_rd_cmp(pin_s[6*NPORT+B+1:6*NPORT+B]),
                .cc1_ra_cmp(pin_s[4*NPORT+B+1:4*NPORT+B]),
                .cc2_ra_cmp(pin_s[2*NPORT+B+1:2*NPORT+B]),
                .frs_low(pin_s[B+1:B]),
                .status(stat[g]),
                .evt(pev[g])
            );
            assign ev_in[EV_W*g+EV_W-1:EV_W*g] = pev[g];
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) port_status[14*g+13:14*g] <= '0;
                else port_status[14*g+13:14*g] <= stat[g];
            end
        end
    endgenerate

    // Strap caught once, on the first valid conversion after reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            strap_r <= '0;
            strap_done_r <= 1'b0;
        end else if (strap_vs && !strap_done_r) begin
            strap_r <= strap_s;
            strap_done_r <= 1'b1;
        end
    end

    // Zero-wait APB: answer in the access phase itself
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd_evt = acc && !pwrite && paddr == OFS_EVT;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r[0] <= CTRL_RST;
            ctrl_r[1] <= CTRL_RST;
            mask_r <= '0;
        end else if (wr) begin
            if (paddr == OFS_CTRL0) ctrl_r[0] <= pwdata[7:0];
            if (paddr == OFS_CTRL1) ctrl_r[1] <= pwdata[7:0];
            if (paddr == OFS_MASK) mask_r <= pwdata[2*EV_W-1:0];
        end
    end

    // Read clears only what it returned, so a late event is not lost; a same-cycle event still sets
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) evt_r <= '0;
        else evt_r <= (rd_evt ? (evt_r & ~prdata[2*EV_W-1:0]) : evt_r) | ev_in;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) irq <= 1'b0;
        else irq <= |(((rd_evt ? (evt_r & ~prdata[2*EV_W-1:0]) : evt_r) | ev_in) & mask_r);
    end

    always_comb begin
        rd_nxt = '0;
        case (paddr)
            OFS_CTRL0: rd_nxt = {24'h000000, ctrl_r[0]};
            OFS_CTRL1: rd_nxt = {24'h000000, ctrl_r[1]};
            OFS_STAT0: rd_nxt = {18'h00000, stat[0]};
            OFS_STAT1: rd_nxt = {18'h00000, stat[1]};
            OFS_EVT: rd_nxt = {24'h000000, evt_r};
            OFS_MASK: rd_nxt = {24'h000000, mask_r};
            OFS_STRAP: rd_nxt = {23'h000000, strap_done_r, strap_r};
            default: rd_nxt = '0;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // Setup cycle registers the answer for the access phase
            pready <= psel && !penable;
            prdata <= (psel && !penable && !pwrite) ? rd_nxt : 32'h00000000;
            pslverr <= psel && !penable && (paddr[1:0] != 2'b00 || paddr > OFS_STRAP);
        end
    end
endmodule

// ---- verification/tcd_cc_partner.sv ----
// Far-side termination model: one code per line becomes comparator levels
`timescale 1ns/100ps
module tcd_cc_partner (
    input wire logic [3:0] term_one,
    input wire logic [3:0] term_two,
    input wire logic [1:0] adv,
    output logic [3:0] one_cmp,
    output logic [3:0] two_cmp,
    output logic [3:0] one_lvl,
    output logic [3:0] two_lvl
);
    // Codes: 0 open, 1 Rd, 2 Ra, 3 pull-up seen by a sink
    function automatic logic [1:0] cmp_of(input logic [1:0] t);
        // Ra sits below both thresholds; Rd, or a partner pull-up against our Rd, below sink-detect only
        return (t == 2'd2) ? 2'b11 : (t == 2'd1 || t == 2'd3) ? 2'b01 : 2'b00;
    endfunction
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            one_cmp[2*p +: 2] = cmp_of(term_one[2*p +: 2]);
            two_cmp[2*p +: 2] = cmp_of(term_two[2*p +: 2]);
            // Strength shows only on a line that this side pulls up
            one_lvl[2*p +: 2] = (term_one[2*p +: 2] == 2'd3) ? adv : 2'b00;
            two_lvl[2*p +: 2] = (term_two[2*p +: 2] == 2'd3) ? adv : 2'b00;
        end
    end
endmodule

// ---- verification/tcd_monitor.sv ----
// Port-level checker for the configuration-channel detect block
`timescale 1ns/100ps
module tcd_monitor (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] vbus_present,
    input wire logic [3:0] cc_line_one_cmp,
    input wire logic [3:0] cc_line_two_cmp,
    input wire logic [27:0] port_status
);
    logic [3:0] st;
    logic pu;
    assign st = port_status[3:0];
    assign pu = port_status[10];
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    // Six cycles outlast the four-cycle pin-to-status path
    sequence src_open6;
        (pu && cc_line_one_cmp[1:0] == 2'b00 && cc_line_two_cmp[1:0] == 2'b00) [*6];
    endsequence
    sequence src_rd_two6;
        (pu && cc_line_one_cmp[1:0] == 2'b00 && cc_line_two_cmp[1:0] == 2'b01) [*6];
    endsequence
    sequence src_debug6;
        (pu && cc_line_one_cmp[1:0] == 2'b01 && cc_line_two_cmp[1:0] == 2'b01) [*6];
    endsequence
    apb_answer_a: assert property (psel && !penable |=> pready && pslverr == (paddr > 8'h18 || paddr[1:0] != 2'b00))
        else $error("APB answer or error flag wrong");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    ufp_power_a: assert property (st == 4'h1 |-> port_status[5] && !port_status[6])
        else $error("sink attach power wrong");
    cable_power_a: assert property (st == 4'h3 |-> port_status[5] && port_status[6])
        else $error("cable with sink power wrong");
    idle_power_a: assert property (st == 4'h0 || st == 4'h2 |-> !port_status[5] && !port_status[6])
        else $error("power applied without sink");
    ufp_orient_a: assert property (src_open6 ##1 src_rd_two6 |-> st == 4'h1 && port_status[4])
        else $error("sink on line two not reported");
    debug_acc_a: assert property (src_open6 ##1 src_debug6 |-> st == 4'h4)
        else $error("debug accessory not reported");
    sink_vbus_a: assert property (!vbus_present[0] [*6] |-> st != 4'h7)
        else $error("sink attached without bus power");
endmodule
bind tcd_top tcd_monitor mon (.mclk, .nrst, .psel, .penable, .paddr, .pready, .pslverr, .vbus_present,
    .cc_line_one_cmp, .cc_line_two_cmp, .port_status);

// ---- verification/tcd_top_tb.sv ----
// Self-checking bench for the two-port detect block
`timescale 1ns/100ps
module tcd_top_tb;
    import tcd_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, strap_valid = 1'b0;
    logic [7:0] paddr = 8'h00, strap = 8'h5a;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq, er;
    logic [1:0] vbus_present = 2'b00, dead_batt = 2'b00, adv = 2'b00;
    logic [3:0] term_one = 4'h0, term_two = 4'h0, swap_low = 4'h0, c1, c2, l1, l2;
    logic [27:0] port_status;
    // Line one, line two, state, orientation checked, orientation, VCONN, VBUS
    logic [15:0] tbl [8] = '{16'h011d, 16'h1019, 16'h2020, 16'h0220, 16'h213f, 16'h123b, 16'h1140, 16'h2250};
    logic [15:0] e;
    int n_mismatch = 0, check_count = 0;
    always #4 mclk = ~mclk;
    tcd_top dut (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .vbus_present, .dead_batt, .cc_line_one_cmp(c1), .cc_line_two_cmp(c2), .cc_line_one_lvl(l1),
        .cc_line_two_lvl(l2), .swap_low, .bus_power_strap(strap), .strap_valid, .port_status, .irq);
    tcd_cc_partner far_end (.term_one, .term_two, .adv, .one_cmp(c1), .two_cmp(c2), .one_lvl(l1), .two_lvl(l2));
    task automatic wrap_up();
        $display("Mismatches %0d in %0d checks", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Request held until the rising edge that samples pready high; answer taken at that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 1, 32'(n < 16));
        if (n >= 16) wrap_up();
    endtask
    task automatic wst(input int p, input logic [3:0] s);
        int n;
        n = 0;
        while (port_status[14*p +: 4] !== s && n < 64) begin
            @(negedge mclk);
            n++;
        end
        chk("state", 32'(s), 32'(port_status[14*p +: 4]));
        if (n >= 64) wrap_up();
        // Let registered side outputs catch up with the state
        repeat (2) @(posedge mclk);
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        strap_valid <= 1'b1;
        repeat (3) @(posedge mclk);
        strap_valid <= 1'b0;
        strap <= 8'ha5;
        apb(0, OFS_CTRL0, 0);
        chk("ctrl reset", 32'(CTRL_RST), rd);
        apb(0, OFS_MASK, 0);
        chk("mask reset", 0, rd);
        apb(0, OFS_STRAP, 0);
        chk("strap", 32'h15a, rd);
        apb(1, 8'h1c, 32'hff);
        chk("bad write", 1, 32'(er));
        apb(0, 8'h1c, 0);
        chk("bad read", 1, {rd[30:0], er});
        apb(0, 8'h02, 0);
        chk("unaligned", 1, 32'(er));
        $display("test registers done");
        for (int v = 0; v < 4; v++) begin
            apb(1, OFS_CTRL0, 32'(v << CF_ADV));
            apb(0, OFS_CTRL0, 0);
            chk("adv", 32'(v << CF_ADV), rd);
            for (int i = 0; i < 8; i++) begin
                e = tbl[i];
                apb(0, OFS_EVT, 0);
                term_one[1:0] <= e[13:12];
                term_two[1:0] <= e[9:8];
                wst(0, e[7:4]);
                if (e[7:4] < 4'h4) chk("power", 32'(e[1:0]), 32'(port_status[6:5]));
                if (e[3]) chk("orient", 32'(e[2]), 32'(port_status[4]));
                if (i == 4) begin
                    term_one[1:0] <= 2'd0;
                    repeat (12) @(posedge mclk);
                    chk("ra ignored", 3, 32'(port_status[3:0]));
                end
                term_one[1:0] <= 2'd0;
                term_two[1:0] <= 2'd0;
                wst(0, 4'h0);
                chk("idle power", 0, 32'(port_status[6:5]));
                apb(0, OFS_EVT, 0);
                if (e[3]) chk("events", 32'h3, rd);
            end
        end
        $display("test source table done");
        apb(1, OFS_MASK, 32'(1 << EV_FRS_RX));
        apb(1, OFS_CTRL0, 32'(ROLE_SNK | (1 << CF_FRS_EN) | (1 << CF_TRIM_SEL)));
        term_two[1:0] <= 2'd3;
        adv <= 2'd2;
        repeat (12) @(posedge mclk);
        chk("sink no vbus", 1, 32'(port_status[3:0] != 4'h7));
        chk("trimmed rd", 1, 32'(port_status[11]));
        vbus_present[0] <= 1'b1;
        wst(0, 4'h7);
        chk("seen level", 2, 32'(port_status[9:8]));
        chk("irq masked", 0, 32'(irq));
        swap_low[1] <= 1'b1;
        repeat (12) @(posedge mclk);
        chk("swap role", 2, 32'({port_status[10], port_status[7]}));
        chk("irq set", 1, 32'(irq));
        swap_low[1] <= 1'b0;
        apb(0, OFS_EVT, 0);
        chk("swap event", 1, 32'(rd[EV_FRS_RX]));
        repeat (3) @(posedge mclk);
        chk("irq clear", 0, 32'(irq));
        vbus_present[0] <= 1'b0;
        term_two[1:0] <= 2'd1;
        apb(1, OFS_CTRL0, 32'(1 << CF_FRS_EN));
        wst(0, 4'h1);
        apb(1, OFS_CTRL0, 32'((1 << CF_FRS_EN) | (1 << CF_FRS_REQ)));
        repeat (12) @(posedge mclk);
        chk("swap sent", 3, 32'({port_status[13], port_status[7]}));
        apb(0, OFS_EVT, 0);
        chk("sent event", 1, 32'(rd[EV_FRS_TX]));
        $display("test sink and swap done");
        term_two[3:2] <= 2'd1;
        wst(1, 4'h1);
        chk("port1 apart", 0, 32'(port_status[27]));
        term_two[3:2] <= 2'd3;
        dead_batt[1] <= 1'b1;
        apb(1, OFS_CTRL1, 32'(ROLE_SNK));
        repeat (12) @(posedge mclk);
        chk("db rd", 2, 32'({port_status[26], port_status[25]}));
        apb(1, OFS_CTRL1, 32'(ROLE_SNK | (1 << CF_TRIM_SEL) | (1 << CF_DB_OFF)));
        repeat (12) @(posedge mclk);
        chk("trim rd", 1, 32'({port_status[26], port_status[25]}));
        $display("test port1 done");
        term_two[3:2] <= 2'd0;
        apb(1, OFS_CTRL1, 32'(ROLE_DRP));
        repeat (8) @(posedge mclk);
        chk("drp pull-down half", 0, 32'(port_status[24]));
        repeat (DRP_HALF_CYC) @(posedge mclk);
        chk("drp pull-up half", 1, 32'(port_status[24]));
        repeat (DRP_HALF_CYC) @(posedge mclk);
        chk("drp back to pull-down", 0, 32'(port_status[24]));
        $display("test dual role done");
        wrap_up();
    end
endmodule
